// >>> core/gps_pkg.sv
// package: register map, reset values and field positions for the gpio port
package gps_pkg;
    localparam int          GPS_WIDTH        = 8;
    localparam logic [11:0] GPS_OFF_LEVEL    = 12'h000;
    localparam logic [11:0] GPS_OFF_LATCH    = 12'h004;
    localparam logic [11:0] GPS_OFF_DIR      = 12'h008;
    localparam logic [11:0] GPS_OFF_ANALOG   = 12'h00C;
    localparam logic [11:0] GPS_OFF_STEER    = 12'h010;
    localparam logic [7:0]  GPS_DIR_RST      = 8'hFF;
    localparam logic [7:0]  GPS_LATCH_RST    = 8'h00;
    localparam logic [7:0]  GPS_ANALOG_MASK  = 8'h2F;
    localparam logic [7:0]  GPS_STEER_MASK   = 8'h03;
    localparam logic [7:0]  GPS_STEER_RST    = 8'h00;
    localparam int          GPS_SS_SEL_BIT   = 1;
    localparam int          GPS_CCP_SEL_BIT  = 0;
    localparam int          GPS_PIN_SS_MAIN  = 5;
    localparam int          GPS_PIN_SS_ALT   = 0;
endpackage : gps_pkg

// >>> core/gps_port.sv
// gpio port with analog select and alternate pin steering, apb slave
// Notes on behaviour
// - direction 1 turns pin driver off; 0 drives latch onto pin
// - level register reads pins, writes go to output latch
// - latch register write same as level write; read returns latch
// - level write is a plain full-byte write into the latch
// - direction still controls driver when pin is analog
// - analog-selected pins read zero digitally
// - analog select disables the pin's digital input buffer
// - analog select leaves digital output untouched
// - implemented analog select bits come up set after reset
// - enabled peripheral owns pin output; pin stays readable
// - steering bit 1 routes slave-select from pin five or pin zero
// - steering bit 0 routes capture unit two output to c1 or alternate pin; its input always comes from the alternate pin
// - steering alters no direction bits; overrides follow selection
// - steering bits 7 to 2 read zero
// - eight bidirectional pins with direction, latch and level bits
// - direction bits reset to one
// - analog bits only at 5 and 3..0, others read zero
`timescale 1ns/1ps
`default_nettype none
module gps_port
    import gps_pkg::*;
#(
    parameter int W = gps_pkg::GPS_WIDTH
) (
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output var  logic [31:0]  prdata,
    output var  logic         pready,
    output var  logic         pslverr,
    input  wire logic [W-1:0] pin_in,
    output var  logic [W-1:0] pin_out,
    output var  logic [W-1:0] pin_oe_n,
    input  wire logic [W-1:0] periph_oe,
    input  wire logic [W-1:0] periph_out,
    input  wire logic         ccp_oe,
    input  wire logic         ccp_out,
    output var  logic         ccp_in,
    input  wire logic         ccp_alt_in,
    output var  logic         ccp_alt_out,
    output var  logic         ccp_alt_oe_n,
    output var  logic         ccp_main_sel,
    output var  logic         slave_select_in,
    output var  logic [W-1:0] digital_in
);
    import gps_pkg::*;

    logic [W-1:0] dir_q, latch_q, analog_q, level_sync;
    logic [7:0]   steer_q;
    logic [W-1:0] level_rd;
    logic [W-1:0] drv_val, drv_en;
    logic         setup, acc_wr;
    logic         hit_lvl, hit_lat, hit_dir, hit_ana, hit_str, hit_any;
    logic [7:0]   rd_byte;
    logic [W-1:0] wr_bits;
    logic         ccp_alt_sync;

    gps_sync #(.W(W)) u_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (pin_in),
        .sync_out (level_sync)
    );

    // alternate capture pin is a pad too, so it gets the same two flops
    gps_sync #(.W(1)) u_ccp_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (ccp_alt_in),
        .sync_out (ccp_alt_sync)
    );

    // analog pins have their input buffer gated off
    assign level_rd = level_sync & ~analog_q;
    assign setup   = psel && !penable;
    assign acc_wr  = psel && penable && pwrite && !hit_err_n();
    assign hit_lvl = (paddr == GPS_OFF_LEVEL);
    assign hit_lat = (paddr == GPS_OFF_LATCH);
    assign hit_dir = (paddr == GPS_OFF_DIR);
    assign hit_ana = (paddr == GPS_OFF_ANALOG);
    assign hit_str = (paddr == GPS_OFF_STEER);
    assign hit_any = hit_lvl | hit_lat | hit_dir | hit_ana | hit_str;
    assign wr_bits = pwdata[W-1:0];

    function automatic logic hit_err_n();
        return !hit_any;
    endfunction : hit_err_n

    assign rd_byte = hit_lvl ? level_rd :
                     hit_lat ? latch_q  :
                     hit_dir ? dir_q    :
                     hit_ana ? (analog_q & GPS_ANALOG_MASK) :
                     hit_str ? (steer_q & GPS_STEER_MASK)   :
                     8'h00;

    // pin drive: peripheral beats latch and direction, else direction gates driver
    generate
        for (genvar i = 0; i < W; i++) begin : g_pin
            assign drv_val[i] = periph_oe[i] ? periph_out[i] : latch_q[i];
            assign drv_en[i]  = periph_oe[i] | ~dir_q[i];
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dir_q    <= GPS_DIR_RST;
            latch_q  <= GPS_LATCH_RST;
            analog_q <= GPS_ANALOG_MASK;
            steer_q  <= GPS_STEER_RST;
        end else if (acc_wr) begin
            // a level write is a plain full-byte write into the latch, same as a latch write
            if (hit_lvl || hit_lat)
                latch_q <= wr_bits;
            if (hit_dir)
                dir_q <= wr_bits;
            if (hit_ana)
                analog_q <= wr_bits & GPS_ANALOG_MASK;
            if (hit_str)
                steer_q <= wr_bits & GPS_STEER_MASK;
        end
    end

    // no wait cycle: answer in the first access cycle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !hit_any;
            prdata  <= (setup && !pwrite) ? {24'h00_0000, rd_byte}
                                          : 32'h0000_0000;
        end
    end

    // pins and steering; capture unit two output steered between c1 and alternate, its input always from alternate
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pin_out         <= '0;
            pin_oe_n        <= '1;
            ccp_in          <= 1'b0;
            ccp_alt_out     <= 1'b0;
            ccp_alt_oe_n    <= 1'b1;
            ccp_main_sel    <= 1'b1;
            slave_select_in <= 1'b1;
            digital_in      <= '0;
        end else begin
            pin_out    <= drv_val;
            pin_oe_n   <= ~drv_en;
            digital_in <= level_rd;
            slave_select_in <= steer_q[GPS_SS_SEL_BIT]
                ? level_rd[GPS_PIN_SS_ALT]
                : level_rd[GPS_PIN_SS_MAIN];
            ccp_main_sel <= !steer_q[GPS_CCP_SEL_BIT];
            ccp_alt_out  <= ccp_out;
            ccp_alt_oe_n <= !(steer_q[GPS_CCP_SEL_BIT] && ccp_oe);
            ccp_in       <= ccp_alt_sync;
        end
    end

    AST_DIR_RESET: assert property (@(posedge ref_clk)
        $fell(reset) |-> dir_q == GPS_DIR_RST)
        else $error("direction not all inputs after reset");
    AST_ANA_RESET: assert property (@(posedge ref_clk)
        $fell(reset) |-> analog_q == GPS_ANALOG_MASK)
        else $error("analog select not set after reset");
    AST_DRV_OFF: assert property (@(posedge ref_clk) disable iff (reset)
        (dir_q[0] && !periph_oe[0]) |=> pin_oe_n[0])
        else $error("driver on with direction input");
    AST_DRV_LAT: assert property (@(posedge ref_clk) disable iff (reset)
        (!dir_q[3] && !periph_oe[3]) |=> (!pin_oe_n[3]
        && pin_out[3] == $past(latch_q[3])))
        else $error("latch not driven");
    AST_ANA_ZERO: assert property (@(posedge ref_clk) disable iff (reset)
        analog_q[2] |=> !digital_in[2])
        else $error("analog pin reads one");
    AST_LVL_WR: assert property (@(posedge ref_clk) disable iff (reset)
        (acc_wr && hit_lvl) |=> latch_q == $past(wr_bits))
        else $error("level write missed latch");
    AST_STEER_RD: assert property (@(posedge ref_clk) disable iff (reset)
        (setup && !pwrite && hit_str) |=> prdata[31:2] == 30'h0)
        else $error("steering reads reserved bits");
    AST_PERIPH: assert property (@(posedge ref_clk) disable iff (reset)
        periph_oe[6] |=> (!pin_oe_n[6] && pin_out[6] == $past(periph_out[6])))
        else $error("peripheral lost ownership");
    AST_ANA_MASK: assert property (@(posedge ref_clk) disable iff (reset)
        (analog_q & ~GPS_ANALOG_MASK) == 8'h00)
        else $error("unimplemented analog bit set");
    AST_READY: assert property (@(posedge ref_clk) disable iff (reset)
        setup |=> pready ##1 !pready)
        else $error("pready timing");

    COV_LVL_WR: cover property (@(posedge ref_clk) acc_wr && hit_lvl);
    COV_SS_ALT: cover property (@(posedge ref_clk) steer_q[GPS_SS_SEL_BIT]);
    COV_ANA_OUT: cover property (@(posedge ref_clk) analog_q[0] && !dir_q[0]);
    COV_CCP_ALT: cover property (@(posedge ref_clk)
        steer_q[GPS_CCP_SEL_BIT] && ccp_oe);
    COV_ERR: cover property (@(posedge ref_clk) pslverr);

    // read data, one cycle after the setup edge
    AST_RD_LVL: assert property (@(posedge ref_clk) disable iff (reset)
        (setup && !pwrite && hit_lvl) |=> prdata[7:0] == $past(level_rd))
        else $error("level read wrong");

    AST_RD_LAT: assert property (@(posedge ref_clk) disable iff (reset)
        (setup && !pwrite && hit_lat) |=> prdata[7:0] == $past(latch_q))
        else $error("latch read wrong");

    AST_RD_DIR: assert property (@(posedge ref_clk) disable iff (reset)
        (setup && !pwrite && hit_dir) |=> prdata[7:0] == $past(dir_q))
        else $error("direction read wrong");

    AST_RD_ANA: assert property (@(posedge ref_clk) disable iff (reset)
        (setup && !pwrite && hit_ana) |=> prdata[7:0] == $past(analog_q))
        else $error("analog select read wrong");

    AST_ERR: assert property (@(posedge ref_clk) disable iff (reset)
        (setup && !hit_any) |=> pslverr)
        else $error("unmapped access not flagged");

    AST_ERR_NONE: assert property (@(posedge ref_clk) disable iff (reset)
        (setup && hit_any) |=> !pslverr)
        else $error("mapped access flagged");

    AST_IDLE_RD: assert property (@(posedge ref_clk) disable iff (reset)
        !setup |=> (prdata == 32'h0000_0000 && !pready))
        else $error("read data or ready outside answer");

    // register writes land at the access edge
    AST_LAT_WR: assert property (@(posedge ref_clk) disable iff (reset)
        (acc_wr && hit_lat) |=> latch_q == $past(wr_bits))
        else $error("latch write missed");

    AST_LAT_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
        !(acc_wr && (hit_lvl || hit_lat)) |=> $stable(latch_q))
        else $error("latch changed without write");

    AST_DIR_WR: assert property (@(posedge ref_clk) disable iff (reset)
        (acc_wr && hit_dir) |=> dir_q == $past(wr_bits))
        else $error("direction write missed");

    AST_DIR_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
        !(acc_wr && hit_dir) |=> $stable(dir_q))
        else $error("direction changed without write");

    AST_ANA_WR: assert property (@(posedge ref_clk) disable iff (reset)
        (acc_wr && hit_ana) |=>
        analog_q == ($past(wr_bits) & GPS_ANALOG_MASK))
        else $error("analog select write wrong");

    AST_STEER_WR: assert property (@(posedge ref_clk) disable iff (reset)
        (acc_wr && hit_str) |=>
        steer_q == ($past(wr_bits) & GPS_STEER_MASK))
        else $error("steering write wrong");

    AST_STEER_MASK: assert property (@(posedge ref_clk) disable iff (reset)
        (steer_q & ~GPS_STEER_MASK) == 8'h00)
        else $error("unimplemented steering bit set");

    // steering of slave select and capture unit two
    AST_SS_MAIN: assert property (@(posedge ref_clk) disable iff (reset)
        !steer_q[GPS_SS_SEL_BIT] |=>
        slave_select_in == $past(level_rd[GPS_PIN_SS_MAIN]))
        else $error("slave select not from pin five");

    AST_SS_ALT: assert property (@(posedge ref_clk) disable iff (reset)
        steer_q[GPS_SS_SEL_BIT] |=>
        slave_select_in == $past(level_rd[GPS_PIN_SS_ALT]))
        else $error("slave select not from pin zero");

    AST_CCP_SEL: assert property (@(posedge ref_clk) disable iff (reset)
        1'b1 |=> ccp_main_sel == !$past(steer_q[GPS_CCP_SEL_BIT]))
        else $error("capture unit selection wrong");

    AST_CCP_OFF: assert property (@(posedge ref_clk) disable iff (reset)
        !steer_q[GPS_CCP_SEL_BIT] |=> ccp_alt_oe_n)
        else $error("unselected alternate pin driven");

    AST_CCP_ON: assert property (@(posedge ref_clk) disable iff (reset)
        (steer_q[GPS_CCP_SEL_BIT] && ccp_oe) |=>
        (!ccp_alt_oe_n && ccp_alt_out == $past(ccp_out)))
        else $error("alternate pin not driven by capture unit");

    AST_DRV_ANA: assert property (@(posedge ref_clk) disable iff (reset)
        (analog_q[1] && dir_q[1] && !periph_oe[1]) |=> pin_oe_n[1])
        else $error("analog input pin driven");

    AST_DIG_IN: assert property (@(posedge ref_clk) disable iff (reset)
        1'b1 |=> digital_in == $past(level_rd))
        else $error("digital input path wrong");
endmodule : gps_port
`default_nettype wire

// >>> core/gps_sync.sv
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
`default_nettype none
module gps_sync #(
    parameter int W = 8
) (
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : gps_sync
`default_nettype wire

// >>> verification/gps_pins.sv
// pad model: driven pins loop back, released pins show the board level
`timescale 1ns/1ps
`default_nettype none
module gps_pins (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] board,
    output var  logic [7:0] pin_in
);
    // a released pin never keeps the last driven value
    always_comb pin_in = (pin_out & ~pin_oe_n) | (board & pin_oe_n);
endmodule : gps_pins
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the gpio port over apb
`timescale 1ns/1ps
`default_nettype none
module tb;
    import gps_pkg::*;
    logic        ref_clk, reset, psel, penable, pwrite, pready, pslverr;
    logic        ccp_in, ccp_aout, ccp_aoe_n, ccp_msel, ss_in, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  pin_in, pin_out, pin_oe_n, board, p_oe, p_out, dig;
    logic        c_oe, c_out, c_ain;
    int          miscompares = 0;
    int          n_checks = 0;

    gps_port i_dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe_n,
        .periph_oe(p_oe), .periph_out(p_out), .ccp_oe(c_oe),
        .ccp_out(c_out), .ccp_in, .ccp_alt_in(c_ain),
        .ccp_alt_out(ccp_aout), .ccp_alt_oe_n(ccp_aoe_n),
        .ccp_main_sel(ccp_msel), .slave_select_in(ss_in),
        .digital_in(dig));
    gps_pins i_pins (.pin_out, .pin_oe_n, .board, .pin_in);

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rc(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        check(rd, {24'h0, e});
    endtask : rc

    // pin path: output stage plus two sync flops plus the input register
    task automatic settle;
        repeat (5) @(posedge ref_clk);
    endtask : settle

    task automatic t_reset;
        rc(GPS_OFF_DIR, 8'hFF);
        rc(GPS_OFF_ANALOG, 8'h2F);
        rc(GPS_OFF_STEER, 8'h00);
        rc(GPS_OFF_LATCH, 8'h00);
        check(32'(pin_oe_n), 32'hFF);
        wr(GPS_OFF_STEER, 8'hFF);
        rc(GPS_OFF_STEER, 8'h03);
        wr(12'h020, 8'h55);
        check(32'(err), 32'h1);
        rc(12'h020, 8'h00);
        wr(GPS_OFF_STEER, 8'h00);
        check(32'(err), 32'h0);
        wr(GPS_OFF_ANALOG, 8'hFF);
        rc(GPS_OFF_ANALOG, 8'h2F);
        $display("test reset and map done");
    endtask : t_reset

    task automatic t_drive;
        wr(GPS_OFF_ANALOG, 8'h00);
        wr(GPS_OFF_DIR, 8'h00);
        wr(GPS_OFF_LEVEL, 8'h5A);
        settle();
        check(32'(pin_out), 32'h5A);
        rc(GPS_OFF_LEVEL, 8'h5A);
        wr(GPS_OFF_DIR, 8'hF0);
        wr(GPS_OFF_LATCH, 8'h3C);
        settle();
        rc(GPS_OFF_LEVEL, 8'hFC);
        rc(GPS_OFF_LATCH, 8'h3C);
        check(32'(pin_oe_n), 32'hF0);
        // analog pins keep driving but read as zero
        wr(GPS_OFF_ANALOG, 8'hFF);
        settle();
        rc(GPS_OFF_LEVEL, 8'hD0);
        check(32'(dig), 32'hD0);
        check({pin_out, pin_oe_n}, 32'h3CF0);
        wr(GPS_OFF_ANALOG, 8'h00);
        p_oe  <= 8'h01;
        p_out <= 8'h01;
        settle();
        check(32'(pin_out[0]), 32'h1);
        rc(GPS_OFF_LEVEL, 8'hFD);
        p_oe  <= 8'h00;
        $display("test drive done");
    endtask : t_drive

    task automatic t_steer;
        wr(GPS_OFF_DIR, 8'hFF);
        board <= 8'h20;
        settle();
        check(32'(ss_in), 32'h1);
        wr(GPS_OFF_STEER, 8'h02);
        settle();
        check(32'(ss_in), 32'h0);
        wr(GPS_OFF_STEER, 8'h01);
        {c_oe, c_out, c_ain} <= 3'b111;
        settle();
        check(32'(ccp_msel), 32'h0);
        check({ccp_aoe_n, ccp_aout, ccp_in}, 32'h3);
        rc(GPS_OFF_DIR, 8'hFF);
        wr(GPS_OFF_STEER, 8'h00);
        settle();
        check({ccp_msel, ccp_aoe_n}, 32'h3);
        $display("test steer done");
    endtask : t_steer

    task automatic final_report;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    initial begin
        #100us;
        miscompares++;
        final_report();
    end

    initial begin
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {board, p_oe, p_out} = {8'hFF, 8'h00, 8'h00};
        {c_oe, c_out, c_ain} = 3'b000;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_drive();
        t_steer();
        final_report();
    end
endmodule : tb
`default_nettype wire
